// file: pkg/adc_fmt_pkg.sv
/*
  Constants and carrier types for the parallel output formatter of a
  pipelined 12-bit sampling converter.
  Assumes the converter core hands over offset-binary codes with over and
  under full-scale flags on the system clock.
*/
// Summary of operation
// - Each result leaves as one 12-bit word, every bit as a true and complementary pair.
// - Bit 11 of the word is the most significant bit, bits counting down to bit 0.
// - Format select low gives two's complement, high gives offset binary.
// - Format select resets low, giving two's complement until the pin level passes the two-stage synchroniser.
// - A sample above positive or below negative full scale drives the true range flag high.
// - The complementary range flag is always the inverse of the true one.
// - A sample is taken on each low to high edge of the sampling clock.
// - A forwarded data clock pair follows the conversion clock for the receiver.
// - Each word appears 11 conversion cycles after its sample, captured on the next rising edge.
// - Full-scale codes are FFF and 000 in binary, 7FF and 800 in two's complement.
// - Above positive full scale the word holds the positive full-scale code and flags range.
package adc_fmt_pkg;

  // Word geometry
  localparam int unsigned WORD_W  = 12;
  localparam int unsigned MSB_POS = 11;

  // Conversion cycles from sample to presented word
  localparam int unsigned LATENCY = 11;

  // Full-scale codes in offset binary
  localparam logic [WORD_W-1:0] FS_POS_BIN = 12'hFFF;
  localparam logic [WORD_W-1:0] FS_NEG_BIN = 12'h000;

  // Full-scale codes in two's complement
  localparam logic [WORD_W-1:0] FS_POS_TWOS = 12'h7FF;
  localparam logic [WORD_W-1:0] FS_NEG_TWOS = 12'h800;

  // Values after reset
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
  localparam logic              FMT_RST  = 1'b0;
  localparam logic              CLK_RST  = 1'b0;

  // One pipelined sample: code and its range flag
  typedef struct packed {
    logic [WORD_W-1:0] code;
    logic              oor;
  } sample_t;

  // One differential output word with its range flag pair
  typedef struct packed {
    logic [WORD_W-1:0] word_true;
    logic [WORD_W-1:0] word_comp;
    logic              flag_true;
    logic              flag_comp;
  } out_word_t;

endpackage

// file: src/adc_parallel_output_formatter.sv
/*
  Output formatter: samples converter results on the rising edge of the
  sampling clock, delays them by a fixed pipeline and presents them as
  differential words with a range flag and a forwarded data clock.
  Assumes the sampling clock arrives asynchronously and is well below half
  the system clock rate; core code and flags are on the system clock.
*/
`timescale 1ns/100ps

module adc_parallel_output_formatter
(
  // Clock and reset
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_n_i,
  // Sampling clock and format select pins
  input  wire logic                             conv_clk_i,
  input  wire logic                             fmt_sel_i,
  // Converter core result, offset binary
  input  wire logic [adc_fmt_pkg::WORD_W-1:0]   core_code_i,
  input  wire logic                             core_over_i,
  input  wire logic                             core_under_i,
  // Differential data word
  output logic      [adc_fmt_pkg::WORD_W-1:0]   data_true_o,
  output logic      [adc_fmt_pkg::WORD_W-1:0]   data_comp_o,
  // Differential range flag
  output logic                                  range_flag_true_o,
  output logic                                  range_flag_comp_o,
  // Forwarded data clock
  output logic                                  fwd_clock_true_o,
  output logic                                  fwd_clock_comp_o
);

  // Synchroniser and edge state
  logic conv_q1_r;
  logic conv_q2_r;
  logic conv_q3_r;
  logic fmt_q1_r;
  logic fmt_s_r;
  logic fwd_r;
  logic fwd_nxt;
  logic conv_edge;

  // Pipeline and output state
  adc_fmt_pkg::sample_t   pipe_r   [adc_fmt_pkg::LATENCY];
  adc_fmt_pkg::sample_t   pipe_nxt [adc_fmt_pkg::LATENCY];
  adc_fmt_pkg::sample_t   in_smp;
  adc_fmt_pkg::out_word_t out_r;
  adc_fmt_pkg::out_word_t out_nxt;

  // Rising edge of the synchronised sampling clock
  assign conv_edge = conv_q2_r & ~conv_q3_r;

  // Forwarded clock follows the conversion clock, rising with each new word
  always_comb
  begin
    fwd_nxt = conv_q2_r;
  end

  // Synchronisers, idle low select after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conv_q1_r <= adc_fmt_pkg::CLK_RST;
      conv_q2_r <= adc_fmt_pkg::CLK_RST;
      conv_q3_r <= adc_fmt_pkg::CLK_RST;
      fmt_q1_r  <= adc_fmt_pkg::FMT_RST;
      fmt_s_r   <= adc_fmt_pkg::FMT_RST;
      fwd_r     <= adc_fmt_pkg::CLK_RST;
    end
    else
    begin
      conv_q1_r <= conv_clk_i;
      conv_q2_r <= conv_q1_r;
      conv_q3_r <= conv_q2_r;
      fmt_q1_r  <= fmt_sel_i;
      fmt_s_r   <= fmt_q1_r;
      fwd_r     <= fwd_nxt;
    end
  end

  // Clamp the core result and flag range excursions
  always_comb
  begin
    in_smp.oor  = core_over_i | core_under_i;
    in_smp.code = core_code_i;
    if (core_over_i)
    begin
      in_smp.code = adc_fmt_pkg::FS_POS_BIN;
    end
    else if (core_under_i)
    begin
      in_smp.code = adc_fmt_pkg::FS_NEG_BIN;
    end
  end

  // Shift the pipeline and format the oldest sample on each sampling edge
  always_comb
  begin
    pipe_nxt = pipe_r;
    out_nxt  = out_r;
    if (conv_edge)
    begin
      pipe_nxt[0] = in_smp;
      for (int i = 1; i < adc_fmt_pkg::LATENCY; i++)
      begin
        pipe_nxt[i] = pipe_r[i-1];
      end
      out_nxt.word_true = pipe_r[adc_fmt_pkg::LATENCY-1].code;
      if (!fmt_s_r)
      begin
        // Two's complement flips the sign bit of the offset code
        out_nxt.word_true[adc_fmt_pkg::MSB_POS] =
          ~pipe_r[adc_fmt_pkg::LATENCY-1].code[adc_fmt_pkg::MSB_POS];
      end
      out_nxt.word_comp = ~out_nxt.word_true;
      out_nxt.flag_true = pipe_r[adc_fmt_pkg::LATENCY-1].oor;
      out_nxt.flag_comp = ~pipe_r[adc_fmt_pkg::LATENCY-1].oor;
    end
  end

  // Pipeline and output registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < adc_fmt_pkg::LATENCY; i++)
      begin
        pipe_r[i] <= '0;
      end
      out_r.word_true <= adc_fmt_pkg::WORD_RST;
      out_r.word_comp <= ~adc_fmt_pkg::WORD_RST;
      out_r.flag_true <= 1'b0;
      out_r.flag_comp <= 1'b1;
    end
    else
    begin
      pipe_r <= pipe_nxt;
      out_r  <= out_nxt;
    end
  end

  // Pins
  assign data_true_o       = out_r.word_true;
  assign data_comp_o       = out_r.word_comp;
  assign range_flag_true_o = out_r.flag_true;
  assign range_flag_comp_o = out_r.flag_comp;
  assign fwd_clock_true_o  = fwd_r;
  assign fwd_clock_comp_o  = ~fwd_r;

  // Checks on the output pairs, word coding, format select, range flag and pipeline
  a_data_pair_inverse: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    data_comp_o == ~data_true_o)
    else $error("data complement not inverse of true");

  a_flag_pair_inverse: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    range_flag_comp_o == ~range_flag_true_o)
    else $error("range flag complement not inverse");

  a_msb_sign_bit: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge && !fmt_s_r |=>
      data_true_o[11] != $past(pipe_r[adc_fmt_pkg::LATENCY-1].code[11]))
    else $error("sign bit not flipped in two's complement");

  a_binary_format: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge && fmt_s_r |=> data_true_o == $past(pipe_r[adc_fmt_pkg::LATENCY-1].code))
    else $error("offset binary word altered");

  a_fmt_idle_low: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !fmt_sel_i [*2] |=> !fmt_s_r)
    else $error("low select did not give two's complement");

  a_range_capture: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge && (core_over_i || core_under_i) |=> pipe_r[0].oor)
    else $error("out of range sample not flagged");

  a_edge_spacing: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(data_true_o) |-> $past(conv_edge))
    else $error("word changed without sampling edge");

  a_fwd_follows: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(fwd_clock_true_o) |-> $past(conv_edge) && fwd_clock_comp_o == 1'b0)
    else $error("forwarded clock out of step");

  a_latency_shift: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge |=> pipe_r[adc_fmt_pkg::LATENCY-1] == $past(pipe_r[adc_fmt_pkg::LATENCY-2]))
    else $error("pipeline did not advance");

  a_fs_codes: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    range_flag_true_o |-> (data_true_o == adc_fmt_pkg::FS_POS_BIN ||
      data_true_o == adc_fmt_pkg::FS_NEG_BIN || data_true_o == adc_fmt_pkg::FS_POS_TWOS ||
      data_true_o == adc_fmt_pkg::FS_NEG_TWOS))
    else $error("flagged word is not a full-scale code");

  a_over_clamp: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge && core_over_i |=> pipe_r[0].code == adc_fmt_pkg::FS_POS_BIN)
    else $error("over range sample not clamped");

  a_flag_with_word: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    conv_edge |=> range_flag_true_o == $past(pipe_r[adc_fmt_pkg::LATENCY-1].oor))
    else $error("range flag not aligned with word");

  c_over_range: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_i) $rose(range_flag_true_o));
  c_binary_mode: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_i) conv_edge && fmt_s_r);
  c_twos_mode: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_i) conv_edge && !fmt_s_r);

endmodule // adc_parallel_output_formatter

// file: test/fmt_receiver.sv
/*
  Receiver model: takes each word on a rising forwarded clock.
  Assumes it samples the device outputs on the system clock.
*/
`timescale 1ns/100ps

module fmt_receiver
(
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // Device outputs
  input  wire adc_fmt_pkg::out_word_t out_i,
  input  wire logic                   fwd_i,
  // Captured word and count of captures
  output adc_fmt_pkg::sample_t        cap_o,
  output logic [15:0]                 cnt_o
);
  adc_fmt_pkg::sample_t held_r;
  logic                 fwd_r;

  // Keep the word seen before each edge, take it at a clock rise
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      held_r <= '0;
      fwd_r  <= 1'b0;
      cap_o  <= '0;
      cnt_o  <= 16'h0000;
    end
    else
    begin
      held_r <= '{out_i.word_true, out_i.flag_true};
      fwd_r  <= fwd_i;
      if (fwd_i && !fwd_r)
      begin
        cap_o <= held_r;
        cnt_o <= cnt_o + 16'h0001;
      end
    end
endmodule // fmt_receiver

// file: test/tb_adc_parallel_output_formatter.sv
/*
  Testbench for the output formatter: latency, coding, range flag.
  Assumes a free-running 125 ns sampling clock and the receiver model.
*/
`timescale 1ns/100ps

module tb_adc_parallel_output_formatter;
  logic                   ref_clk_i = 1'b0;
  logic                   rst_n_i   = 1'b0;
  logic                   conv_clk  = 1'b0;
  logic                   fmt_sel   = 1'b0;
  logic                   over      = 1'b0;
  logic                   under     = 1'b0;
  logic [11:0]            code      = 12'h000;
  logic [11:0]            p_code    = 12'h000;
  logic                   p_ov      = 1'b0;
  logic                   p_un      = 1'b0;
  logic                   fwd_t;
  logic                   fwd_c;
  logic [11:0]            d_true;
  logic [11:0]            d_comp;
  logic                   f_true;
  logic                   f_comp;
  adc_fmt_pkg::out_word_t ow;
  adc_fmt_pkg::sample_t   cap;
  logic [15:0]            cnt;
  int                     n_errors   = 0;
  int                     n_compared = 0;
  int                     cycles     = 0;

  // System clock and unrelated sampling clock
  always #2 ref_clk_i = ~ref_clk_i;
  initial #1.3 forever #62.5 conv_clk = ~conv_clk;

  adc_parallel_output_formatter dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .conv_clk_i(conv_clk), .fmt_sel_i(fmt_sel), .core_code_i(code), .core_over_i(over),
    .core_under_i(under), .data_true_o(d_true), .data_comp_o(d_comp),
    .range_flag_true_o(f_true), .range_flag_comp_o(f_comp),
    .fwd_clock_true_o(fwd_t), .fwd_clock_comp_o(fwd_c));

  // Gather the output pins into one carrier, single driver
  assign ow = {d_true, d_comp, f_true, f_comp};

  fmt_receiver rx_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .out_i(ow), .fwd_i(fwd_t),
    .cap_o(cap), .cnt_o(cnt));

  // Expected word from raw code, range inputs and format
  function automatic logic [11:0] fmt_of(input logic [11:0] c, input logic ov, un, fm);
    logic [11:0] v;
    v = ov ? 12'hFFF : (un ? 12'h000 : c);
    return fm ? v : {~v[11], v[10:0]};
  endfunction

  task automatic chk_w(input logic [11:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for a capture count
  task automatic wait_cap(input logic [15:0] n);
    for (int k = 0; k < 500 && cnt !== n; k++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    if (cnt !== n)
    begin
      n_errors++;
      $display("Error at %0t: capture %0d not reached", $time, n);
    end
  endtask

  // New sample while the clock is low, check the 12th and 13th captures
  task automatic step(input logic [11:0] c, input logic ov, un, fm);
    logic [15:0] n0;
    @(negedge conv_clk);
    @(posedge ref_clk_i);
    #1;
    n0 = cnt;
    code = c;
    over = ov;
    under = un;
    fmt_sel = fm;
    wait_cap(n0 + 16'h000C);
    chk_w(cap.code, fmt_of(p_code, p_ov, p_un, fm));
    chk_b(cap.oor, p_ov | p_un);
    wait_cap(n0 + 16'h000D);
    chk_w(cap.code, fmt_of(c, ov, un, fm));
    chk_b(cap.oor, ov | un);
    chk_w(ow.word_comp, ~ow.word_true);
    chk_b(ow.flag_comp, ~ow.flag_true);
    chk_b(fwd_c, ~fwd_t);
    p_code = c;
    p_ov = ov;
    p_un = un;
  endtask

  task automatic test_reset();
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk_w(ow.word_true, 12'h000);
    chk_w(ow.word_comp, 12'hFFF);
    chk_b(ow.flag_true, 1'b0);
    chk_b(ow.flag_comp, 1'b1);
    chk_b(fwd_t, 1'b0);
    chk_b(fwd_c, 1'b1);
    rst_n_i = 1'b1;
    wait_cap(16'h000E);
    chk_w(cap.code, 12'h800);
    $display("Test reset done");
  endtask

  task automatic test_format();
    step(12'h800, 1'b0, 1'b0, 1'b0);
    step(12'h123, 1'b0, 1'b0, 1'b1);
    step(12'hFFF, 1'b0, 1'b0, 1'b0);
    step(12'h000, 1'b0, 1'b0, 1'b1);
    step(12'h000, 1'b0, 1'b0, 1'b0);
    $display("Test format done");
  endtask

  task automatic test_range();
    step(12'h555, 1'b1, 1'b0, 1'b1);
    step(12'h555, 1'b1, 1'b0, 1'b0);
    step(12'h555, 1'b0, 1'b1, 1'b0);
    step(12'hABC, 1'b0, 1'b1, 1'b1);
    step(12'h3C3, 1'b0, 1'b0, 1'b1);
    $display("Test range done");
  endtask

  // Cut a hang short
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end

  initial
  begin
    #1;
    test_reset();
    test_format();
    test_range();
    end_sim();
  end
endmodule // tb_adc_parallel_output_formatter
